/* File: hw/ring_descriptor_fields.sv */
// Descriptor ring engine: AHB-Lite view of the rings plus transmit and receive walkers.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module ring_descriptor_fields (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic [31:0]                        hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic                               tx_buf_valid,
	output logic [23:0]                        tx_buf_addr,
	output logic [11:0]                        tx_buf_len,
	output logic                               tx_first,
	output logic                               tx_last,
	output logic                               tx_fcs_on,
	input  wire logic                          tx_buf_done,
	input  wire logic                          underrun_error,
	input  wire logic                          late_collision_error,
	input  wire logic                          carrier_lost_error,
	input  wire logic                          retry_exhausted_error,
	input  wire logic                          waited_for_channel,
	input  wire logic [ring_pkg::RETRY_W-1:0]  tx_retries,
	output logic                               rx_buf_valid,
	output logic [23:0]                        rx_buf_addr,
	output logic [11:0]                        rx_buf_len,
	input  wire logic                          rx_buf_done,
	input  wire logic                          rx_buf_last,
	input  wire logic [11:0]                   rx_frame_len,
	input  wire logic                          rx_frame_err
);
	import ring_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [11:0] neg_len(input logic [11:0] b);
		return ~b + 12'h001;
	endfunction

	function automatic logic desc_hit(input logic [11:0] a, input logic [11:0] base);
		return (a & DESC_MASK) == base;
	endfunction

	// ************************************************************
	// Storage and state
	// ************************************************************
	logic [31:0]        tx_mem [DESC_COUNT*2];
	logic [31:0]        rx_mem [DESC_COUNT*2];
	logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic               dp_valid_q, dp_valid_d;
	logic               dp_write_q, dp_write_d;
	logic [11:0]        dp_addr_q, dp_addr_d;
	logic [31:0]        hrdata_q, hrdata_d;
	logic               hreadyout_q;
	logic               acc, bus_wr;
	logic [31:0]        rd_word;

	tx_state_t          tx_state_q, tx_state_d;
	logic [IDX_W-1:0]   tx_idx_q, tx_idx_d;
	logic               tx_in_frame_q, tx_in_frame_d;
	logic               tx_valid_q, tx_valid_d;
	logic [23:0]        tx_addr_q, tx_addr_d;
	logic [11:0]        tx_len_q, tx_len_d;
	logic               tx_first_q, tx_first_d;
	logic               tx_last_q, tx_last_d;
	logic               tx_fcs_q, tx_fcs_d;
	logic [9:0]         tx_stat_q, tx_stat_d;
	logic               tx_we;
	logic [31:0]        tx_cur_w0, tx_wword;
	logic [15:0]        tx_cur_ctrl;
	logic [23:0]        tx_cur_addr;
	logic               fcs_expect;

	rx_state_t          rx_state_q, rx_state_d;
	logic [IDX_W-1:0]   rx_idx_q, rx_idx_d;
	logic               rx_first_q, rx_first_d;
	logic               rx_valid_q, rx_valid_d;
	logic [23:0]        rx_addr_q, rx_addr_d;
	logic [11:0]        rx_len_q, rx_len_d;
	logic               rx_last_q, rx_last_d;
	logic               rx_err_q, rx_err_d;
	logic [11:0]        rx_flen_q, rx_flen_d;
	logic               rx_we;
	logic [31:0]        rx_cur_w0, rx_cur_w1, rx_w0, rx_w1;

	tx_merge_if         mif ();

	tx_status_merge u_merge (
		.m (mif.merge)
	);

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	assign acc = hsel & htrans[1] & hready;
	assign bus_wr = dp_valid_q & dp_write_q;

	always_comb
	begin
		rd_word = MEM_RESET;
		if (haddr[11:0] == CTRL_OFF)
			rd_word[CTRL_W-1:0] = ctrl_q;
		else if (haddr[11:0] == STAT_OFF)
		begin
			rd_word[IDX_W-1:0] = tx_idx_q;
			rd_word[ST_RX_IDX_LSB +: IDX_W] = rx_idx_q;
			rd_word[ST_TX_FRAME_BIT] = tx_in_frame_q;
			rd_word[ST_RX_FIRST_BIT] = rx_first_q;
			rd_word[ST_TX_BUSY_BIT] = tx_state_q != TX_IDLE;
			rd_word[ST_RX_BUSY_BIT] = rx_state_q != RX_IDLE;
		end
		else if (desc_hit(haddr[11:0], TX_BASE))
			rd_word = tx_mem[haddr[4:2]];
		else if (desc_hit(haddr[11:0], RX_BASE))
			rd_word = rx_mem[haddr[4:2]];
	end

	always_comb
	begin
		dp_valid_d = acc;
		dp_write_d = acc & hwrite;
		dp_addr_d = acc ? haddr[11:0] : dp_addr_q;
		hrdata_d = hrdata_q;
		ctrl_d = ctrl_q;
		if (acc && !hwrite)
		begin
			hrdata_d = rd_word;
			if (bus_wr && dp_addr_q == haddr[11:0] && (desc_hit(dp_addr_q, TX_BASE)
				|| desc_hit(dp_addr_q, RX_BASE)))
				hrdata_d = hwdata;
			else if (bus_wr && dp_addr_q == haddr[11:0] && dp_addr_q == CTRL_OFF)
				hrdata_d[CTRL_W-1:0] = hwdata[CTRL_W-1:0];
		end
		if (bus_wr && dp_addr_q == CTRL_OFF)
			ctrl_d = hwdata[CTRL_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= CTRL_OFF;
			hrdata_q <= MEM_RESET;
			hreadyout_q <= 1'b1;
			ctrl_q <= CTRL_RESET;
		end
		else
		begin
			dp_valid_q <= dp_valid_d;
			dp_write_q <= dp_write_d;
			dp_addr_q <= dp_addr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			ctrl_q <= ctrl_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = HRESP_OKAY;

	// ************************************************************
	// Descriptor memory
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < DESC_COUNT*2; i++)
			begin
				tx_mem[i] <= MEM_RESET;
				rx_mem[i] <= MEM_RESET;
			end
		end
		else
		begin
			if (bus_wr && desc_hit(dp_addr_q, TX_BASE))
				tx_mem[dp_addr_q[4:2]] <= hwdata;
			if (bus_wr && desc_hit(dp_addr_q, RX_BASE))
				rx_mem[dp_addr_q[4:2]] <= hwdata;
			if (tx_we)
				tx_mem[{tx_idx_q, 1'b0}] <= tx_wword;
			if (rx_we)
			begin
				rx_mem[{rx_idx_q, 1'b0}] <= rx_w0;
				rx_mem[{rx_idx_q, 1'b1}] <= rx_w1;
			end
		end
	end

	// ************************************************************
	// Transmit walker
	// ************************************************************
	assign tx_cur_w0 = tx_mem[{tx_idx_q, 1'b0}];
	assign tx_cur_ctrl = tx_cur_w0[31:16];
	assign tx_cur_addr = {tx_cur_ctrl[7:0], tx_cur_w0[15:0]};
	assign fcs_expect = tx_cur_ctrl[FCS_BIT] | ~ctrl_q[CTRL_FCS_DIS_BIT];

	assign mif.old_ctrl = tx_cur_ctrl;
	assign mif.underrun_error = tx_stat_q[9];
	assign mif.late_collision_error = tx_stat_q[8];
	assign mif.carrier_lost_error = tx_stat_q[7];
	assign mif.retry_exhausted_error = tx_stat_q[6];
	assign mif.waited_for_channel = tx_stat_q[5];
	assign mif.retries = tx_stat_q[4:0];
	assign tx_wword = {mif.new_ctrl, tx_cur_w0[15:0]};

	always_comb
	begin
		tx_state_d = tx_state_q;
		tx_idx_d = tx_idx_q;
		tx_in_frame_d = tx_in_frame_q;
		tx_valid_d = tx_valid_q;
		tx_addr_d = tx_addr_q;
		tx_len_d = tx_len_q;
		tx_first_d = tx_first_q;
		tx_last_d = tx_last_q;
		tx_fcs_d = tx_fcs_q;
		tx_stat_d = tx_stat_q;
		tx_we = 1'b0;
		case (tx_state_q)
			TX_IDLE:
				if (ctrl_q[CTRL_TX_EN_BIT])
					tx_state_d = TX_POLL;
			TX_POLL:
				if (!ctrl_q[CTRL_TX_EN_BIT] && !tx_in_frame_q)
					tx_state_d = TX_IDLE;
				else if (tx_cur_ctrl[OWN_BIT] && (tx_in_frame_q || tx_cur_ctrl[STP_BIT]))
				begin
					tx_valid_d = 1'b1;
					tx_addr_d = tx_cur_addr;
					tx_len_d = neg_len(tx_mem[{tx_idx_q, 1'b1}][11:0]);
					tx_first_d = tx_cur_ctrl[STP_BIT];
					tx_last_d = tx_cur_ctrl[ENP_BIT];
					if (tx_cur_ctrl[STP_BIT])
						tx_fcs_d = fcs_expect;
					tx_state_d = TX_SEND;
				end
				else if (tx_cur_ctrl[OWN_BIT])
					tx_idx_d = tx_idx_q + 2'h1;
			TX_SEND:
				if (tx_buf_done)
				begin
					tx_valid_d = 1'b0;
					tx_stat_d = {underrun_error, late_collision_error, carrier_lost_error,
						retry_exhausted_error, waited_for_channel, tx_retries};
					tx_state_d = TX_WB;
				end
			default:
				if (!bus_wr)
				begin
					tx_we = 1'b1;
					tx_idx_d = tx_idx_q + 2'h1;
					tx_in_frame_d = ~(tx_last_q | mif.err);
					tx_state_d = TX_POLL;
				end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_state_q <= TX_IDLE;
			tx_idx_q <= '0;
			tx_in_frame_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_addr_q <= '0;
			tx_len_q <= '0;
			tx_first_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_fcs_q <= 1'b0;
			tx_stat_q <= '0;
		end
		else
		begin
			tx_state_q <= tx_state_d;
			tx_idx_q <= tx_idx_d;
			tx_in_frame_q <= tx_in_frame_d;
			tx_valid_q <= tx_valid_d;
			tx_addr_q <= tx_addr_d;
			tx_len_q <= tx_len_d;
			tx_first_q <= tx_first_d;
			tx_last_q <= tx_last_d;
			tx_fcs_q <= tx_fcs_d;
			tx_stat_q <= tx_stat_d;
		end
	end

	assign tx_buf_valid = tx_valid_q;
	assign tx_buf_addr = tx_addr_q;
	assign tx_buf_len = tx_len_q;
	assign tx_first = tx_first_q;
	assign tx_last = tx_last_q;
	assign tx_fcs_on = tx_fcs_q;

	// ************************************************************
	// Receive walker
	// ************************************************************
	assign rx_cur_w0 = rx_mem[{rx_idx_q, 1'b0}];
	assign rx_cur_w1 = rx_mem[{rx_idx_q, 1'b1}];

	always_comb
	begin
		rx_w0 = rx_cur_w0;
		rx_w0[16+OWN_BIT] = 1'b0;
		rx_w0[16+ERR_BIT] = rx_err_q;
		rx_w0[16+STP_BIT] = rx_first_q;
		rx_w0[16+ENP_BIT] = rx_last_q;
		rx_w1 = rx_cur_w1;
		rx_w1[31:28] = UNUSED_BITS_VAL;
		rx_w1[27:16] = (rx_last_q && !rx_err_q) ? rx_flen_q : LEN_NONE;
	end

	always_comb
	begin
		rx_state_d = rx_state_q;
		rx_idx_d = rx_idx_q;
		rx_first_d = rx_first_q;
		rx_valid_d = rx_valid_q;
		rx_addr_d = rx_addr_q;
		rx_len_d = rx_len_q;
		rx_last_d = rx_last_q;
		rx_err_d = rx_err_q;
		rx_flen_d = rx_flen_q;
		rx_we = 1'b0;
		case (rx_state_q)
			RX_IDLE:
				if (ctrl_q[CTRL_RX_EN_BIT])
					rx_state_d = RX_POLL;
			RX_POLL:
				if (!ctrl_q[CTRL_RX_EN_BIT] && rx_first_q)
					rx_state_d = RX_IDLE;
				else if (rx_cur_w0[16+OWN_BIT])
				begin
					rx_valid_d = 1'b1;
					rx_addr_d = {rx_cur_w0[23:16], rx_cur_w0[15:0]};
					rx_len_d = neg_len(rx_cur_w1[11:0]);
					rx_state_d = RX_FILL;
				end
			RX_FILL:
				if (rx_buf_done)
				begin
					rx_valid_d = 1'b0;
					rx_last_d = rx_buf_last;
					rx_err_d = rx_frame_err;
					rx_flen_d = rx_frame_len;
					rx_state_d = RX_WB;
				end
			default:
				if (!bus_wr)
				begin
					rx_we = 1'b1;
					rx_idx_d = rx_idx_q + 2'h1;
					rx_first_d = rx_last_q | rx_err_q;
					rx_state_d = RX_POLL;
				end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_state_q <= RX_IDLE;
			rx_idx_q <= '0;
			rx_first_q <= 1'b1;
			rx_valid_q <= 1'b0;
			rx_addr_q <= '0;
			rx_len_q <= '0;
			rx_last_q <= 1'b0;
			rx_err_q <= 1'b0;
			rx_flen_q <= '0;
		end
		else
		begin
			rx_state_q <= rx_state_d;
			rx_idx_q <= rx_idx_d;
			rx_first_q <= rx_first_d;
			rx_valid_q <= rx_valid_d;
			rx_addr_q <= rx_addr_d;
			rx_len_q <= rx_len_d;
			rx_last_q <= rx_last_d;
			rx_err_q <= rx_err_d;
			rx_flen_q <= rx_flen_d;
		end
	end

	assign rx_buf_valid = rx_valid_q;
	assign rx_buf_addr = rx_addr_q;
	assign rx_buf_len = rx_len_q;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_tx_err_summary: assert property (tx_we |-> tx_wword[16+ERR_BIT] ==
		(|tx_stat_q[9:6])) else $error("error summary differs from flags");
	a_tx_haddr_kept: assert property (tx_we |-> tx_wword[23:16] == tx_cur_w0[23:16]
		&& !tx_wword[16+OWN_BIT]) else $error("tx writeback altered address");
	a_tx_flags_gated: assert property (tx_we && !tx_wword[16+ENP_BIT] && !mif.err
		|-> tx_wword[28:26] == 3'h0) else $error("retry flags without last");
	a_tx_addr_join: assert property ($rose(tx_valid_q) |-> tx_addr_q ==
		$past(tx_cur_addr)) else $error("tx buffer address not joined");
	a_fcs_select: assert property ($rose(tx_valid_q) && tx_first_q |-> tx_fcs_q ==
		$past(fcs_expect)) else $error("frame check select wrong");
	a_skip_no_first: assert property (tx_state_q == TX_POLL && !tx_in_frame_q
		&& ctrl_q[CTRL_TX_EN_BIT] && tx_cur_ctrl[OWN_BIT] && !tx_cur_ctrl[STP_BIT]
		|=> tx_idx_q == $past(tx_idx_q) + 2'h1 && !tx_valid_q)
		else $error("descriptor without first flag not skipped");
	a_rx_len_write: assert property (rx_we && rx_last_q && !rx_err_q |->
		rx_w1[27:16] == rx_flen_q) else $error("rx frame length wrong");
	a_rx_unused_zero: assert property (rx_we |-> rx_w1[31:28] == UNUSED_BITS_VAL
		&& rx_w1[15:0] == rx_cur_w1[15:0]) else $error("rx length word altered");
	a_rx_flag_write: assert property (rx_we |-> !rx_w0[16+OWN_BIT] &&
		rx_w0[16+STP_BIT] == rx_first_q && rx_w0[16+ENP_BIT] == rx_last_q)
		else $error("rx ownership or frame flags wrong");
	a_rx_len_neg: assert property ($rose(rx_valid_q) |-> rx_len_q + $past(rx_cur_w1[11:0])
		== LEN_NONE) else $error("rx buffer size not negated");
endmodule

/* File: hw/ring_pkg.sv */
// Constants and types shared by the ring descriptor engine and its status merge.
// Contract
// - Top nibble of the receive message count word is written as zero.
// - Device writes the received frame length as an unsigned twelve-bit count.
// - Frame length holds only with error clear and last flag set; host clears it.
// - Transmit owner bit: host sets after filling, device clears after sending.
// - Neither party touches a descriptor after handing it over.
// - Transmit error summary is the OR of the four transmit error flags.
// - Error summary goes into whichever descriptor is current at the error.
// - Per-frame check insert, read at frame start, overrides the global disable.
// - Device sets the multiple-retry flag when more than one retry occurred.
// - Device sets the single-retry flag for exactly one retry; the code leaves it clear when a late collision is flagged.
// - Device sets the deferred flag when it waited for a busy channel.
// - Retry and deferred flags appear only with last flag or error summary set.
// - Owned descriptors without first flag are skipped until an owned first appears.
// - Receive: device clears ownership after filling, host sets it after emptying.
// - Device writes receive first and last flags for each incoming frame.
package ring_pkg;
	localparam int unsigned DESC_COUNT       = 4;
	localparam int unsigned IDX_W            = 2;
	localparam int unsigned WIDX_W           = 3;
	localparam int unsigned RETRY_W          = 5;
	localparam int unsigned CTRL_W           = 3;
	localparam int unsigned OWN_BIT          = 15;
	localparam int unsigned ERR_BIT          = 14;
	localparam int unsigned FCS_BIT          = 13;
	localparam int unsigned MORE_BIT         = 12;
	localparam int unsigned ONE_BIT          = 11;
	localparam int unsigned DEF_BIT          = 10;
	localparam int unsigned STP_BIT          = 9;
	localparam int unsigned ENP_BIT          = 8;
	localparam int unsigned CTRL_FCS_DIS_BIT = 0;
	localparam int unsigned CTRL_TX_EN_BIT   = 1;
	localparam int unsigned CTRL_RX_EN_BIT   = 2;
	localparam int unsigned ST_RX_IDX_LSB    = 4;
	localparam int unsigned ST_TX_FRAME_BIT  = 8;
	localparam int unsigned ST_RX_FIRST_BIT  = 9;
	localparam int unsigned ST_TX_BUSY_BIT   = 12;
	localparam int unsigned ST_RX_BUSY_BIT   = 13;
	localparam logic [11:0] CTRL_OFF         = 12'h000;
	localparam logic [11:0] STAT_OFF         = 12'h004;
	localparam logic [11:0] TX_BASE          = 12'h100;
	localparam logic [11:0] RX_BASE          = 12'h200;
	localparam logic [11:0] DESC_MASK        = 12'hfe0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [31:0] MEM_RESET        = 32'h0000_0000;
	localparam logic [3:0]  UNUSED_BITS_VAL  = 4'h0;
	localparam logic [11:0] LEN_NONE         = 12'h000;
	localparam logic        HRESP_OKAY       = 1'b0;

	typedef enum logic [1:0] {TX_IDLE, TX_POLL, TX_SEND, TX_WB} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_POLL, RX_FILL, RX_WB} rx_state_t;
endpackage

/* File: hw/tx_merge_if.sv */
// Interface carrying a transmit descriptor control word and its completion status.
`timescale 1ns/10ps
interface tx_merge_if;
	import ring_pkg::*;
	logic [15:0]        old_ctrl;
	logic               underrun_error;
	logic               late_collision_error;
	logic               carrier_lost_error;
	logic               retry_exhausted_error;
	logic               waited_for_channel;
	logic [RETRY_W-1:0] retries;
	logic [15:0]        new_ctrl;
	logic               err;

	modport merge (
		input  old_ctrl, underrun_error, late_collision_error, carrier_lost_error,
		input  retry_exhausted_error, waited_for_channel, retries,
		output new_ctrl, err
	);
	modport engine (
		output old_ctrl, underrun_error, late_collision_error, carrier_lost_error,
		output retry_exhausted_error, waited_for_channel, retries,
		input  new_ctrl, err
	);
endinterface

/* File: hw/tx_status_merge.sv */
// Builds the transmit control word written back when a buffer completes.
`timescale 1ns/10ps
module tx_status_merge (
	tx_merge_if.merge m
);
	import ring_pkg::*;

	logic meaningful;

	always_comb
	begin
		m.err = m.underrun_error | m.late_collision_error | m.carrier_lost_error
			| m.retry_exhausted_error;
		meaningful = m.old_ctrl[ENP_BIT] | m.err;
		m.new_ctrl = m.old_ctrl;
		m.new_ctrl[OWN_BIT] = 1'b0;
		m.new_ctrl[ERR_BIT] = m.err;
		m.new_ctrl[MORE_BIT] = meaningful & (m.retries > 5'h01);
		m.new_ctrl[ONE_BIT] = meaningful & (m.retries == 5'h01)
			& ~m.late_collision_error;
		m.new_ctrl[DEF_BIT] = meaningful & m.waited_for_channel;
	end
endmodule

/* File: verif/host_model.sv */
// Host driver model: AHB-Lite master that posts ring descriptors.
`timescale 1ns/10ps
module host_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	import ring_pkg::*;
	// ********************************
	// Bus cycles and descriptor posting.
	// ********************************
	initial
	begin
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'hffff_ffff, q);
	endtask

	task automatic tx_post(input logic [1:0] i, input logic [15:0] c, input logic [15:0] lo,
		input logic [11:0] n);
		wr(TX_BASE + {7'h0, i, 3'h0} + 12'h004, {16'h0, 4'hf, n});
		wr(TX_BASE + {7'h0, i, 3'h0}, {c, lo});
	endtask

	task automatic rx_post(input logic [1:0] i, input logic [7:0] h, input logic [15:0] lo,
		input logic [11:0] n);
		wr(RX_BASE + {7'h0, i, 3'h0} + 12'h004, {16'hf000, 4'hf, n});
		wr(RX_BASE + {7'h0, i, 3'h0}, {8'h80, h, lo});
	endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the descriptor ring engine.
`timescale 1ns/10ps
module testbench;
	import ring_pkg::*;
	// ********************************
	// Signals, instances and checks.
	// ********************************
	logic               hclk = 1'b0;
	logic               hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]        haddr, hwdata, hrdata, q;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic               tx_buf_valid, tx_first, tx_last, tx_fcs_on, tx_buf_done;
	logic [23:0]        tx_buf_addr, rx_buf_addr;
	logic [11:0]        tx_buf_len, rx_buf_len, rx_frame_len;
	logic               underrun_error, late_collision_error, carrier_lost_error;
	logic               retry_exhausted_error, waited_for_channel;
	logic [RETRY_W-1:0] tx_retries;
	logic               rx_buf_valid, rx_buf_done, rx_buf_last, rx_frame_err;
	int                 error_cnt = 0;
	int                 check_count = 0;
	int                 cyc = 0;

	host_model i_host_model (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata);
	ring_descriptor_fields i_ring_descriptor_fields (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.tx_buf_valid, .tx_buf_addr, .tx_buf_len, .tx_first, .tx_last, .tx_fcs_on,
		.tx_buf_done, .underrun_error, .late_collision_error, .carrier_lost_error,
		.retry_exhausted_error, .waited_for_channel, .tx_retries, .rx_buf_valid,
		.rx_buf_addr, .rx_buf_len, .rx_buf_done, .rx_buf_last, .rx_frame_len, .rx_frame_err);

	always #2 hclk = ~hclk;

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("mismatch at %0t: timeout", $time);
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Expected write-back of a transmit control word; e is {underrun, late, carrier, retry}.
	function automatic logic [15:0] tx_back(input logic [15:0] c, input logic [3:0] e,
		input logic [4:0] r, input logic w);
		logic [15:0] x;
		x = c;
		x[OWN_BIT] = 1'b0;
		if (c[ENP_BIT] || (|e))
		begin
			x[ERR_BIT] = |e;
			x[MORE_BIT] = r > 5'd1;
			x[ONE_BIT] = (r == 5'd1) && !e[2];
			x[DEF_BIT] = w;
		end
		return x;
	endfunction

	task automatic tx_buf(input logic [1:0] i, input logic [15:0] c, input logic [3:0] e,
		input logic [4:0] r, input logic w, input logic fcs);
		logic [15:0] lo;
		lo = {6'h0, i, 8'h5a};
		i_host_model.tx_post(i, c, lo, 12'hf9c);
		for (int n = 0; n < 40 && tx_buf_valid !== 1'b1; n++)
			@(posedge hclk);
		chk({8'h0, tx_buf_addr}, {8'h0, c[7:0], lo}, "tx addr");
		chk({20'h0, tx_buf_len}, 32'd100, "tx len");
		chk({tx_first, tx_last, tx_fcs_on}, {c[STP_BIT], c[ENP_BIT], fcs}, "tx flags");
		{underrun_error, late_collision_error, carrier_lost_error, retry_exhausted_error} <= e;
		tx_retries <= r;
		waited_for_channel <= w;
		tx_buf_done <= 1'b1;
		@(posedge hclk);
		tx_buf_done <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({31'h0, tx_buf_valid}, 32'h0, "tx valid after done");
		i_host_model.rd(TX_BASE + {7'h0, i, 3'h0}, q);
		chk(q, {tx_back(c, e, r, w), lo}, "tx word0");
		i_host_model.rd(TX_BASE + {7'h0, i, 3'h0} + 12'h004, q);
		chk(q, 32'h0000_ff9c, "tx word1");
	endtask

	task automatic rx_buf(input logic [1:0] i, input logic last, input logic [11:0] len,
		input logic err, input logic first);
		logic [15:0] lo;
		lo = {6'h0, i, 8'ha5};
		i_host_model.rx_post(i, 8'h3c, lo, 12'hc00);
		for (int n = 0; n < 40 && rx_buf_valid !== 1'b1; n++)
			@(posedge hclk);
		chk({8'h0, rx_buf_addr}, {16'h3c, lo}, "rx addr");
		chk({20'h0, rx_buf_len}, 32'd1024, "rx len");
		rx_buf_last <= last;
		rx_frame_len <= len;
		rx_frame_err <= err;
		rx_buf_done <= 1'b1;
		@(posedge hclk);
		rx_buf_done <= 1'b0;
		repeat (2) @(posedge hclk);
		i_host_model.rd(RX_BASE + {7'h0, i, 3'h0}, q);
		chk(q, {1'b0, err, 4'h0, first, last, 8'h3c, lo}, "rx word0");
		i_host_model.rd(RX_BASE + {7'h0, i, 3'h0} + 12'h004, q);
		chk(q, {4'h0, (last && !err) ? len : 12'h0, 16'hfc00}, "rx word1");
	endtask

	task automatic reset_and_map();
		chk({30'h0, hreadyout, hresp}, 32'h2, "bus idle");
		chk({30'h0, tx_buf_valid, rx_buf_valid}, 32'h0, "links idle");
		i_host_model.rd(12'h040, q);
		chk(q, 32'h0, "unmapped read");
		i_host_model.wr(CTRL_OFF, 32'h7);
		i_host_model.rd(CTRL_OFF, q);
		chk(q, 32'h7, "control");
	endtask

	task automatic tx_chain();
		i_host_model.tx_post(2'd0, 16'h80c1, 16'h1234, 12'hf9c);
		tx_buf(2'd1, 16'ha2c1, 4'h0, 5'd1, 1'b1, 1'b1);
		tx_buf(2'd2, 16'h81c1, 4'h0, 5'd3, 1'b1, 1'b1);
		i_host_model.rd(TX_BASE, q);
		chk(q, 32'h80c1_1234, "skipped desc");
		i_host_model.wr(TX_BASE, 32'h0);
	endtask

	task automatic tx_errors();
		for (int k = 0; k < 4; k++)
			tx_buf(2'(k + 3), 16'h83a0 | (k[0] ? 16'h2000 : 16'h0), 4'h8 >> k, 5'd1, 1'b0, k[0]);
		tx_buf(2'd3, 16'h82a0, 4'h1, 5'd2, 1'b1, 1'b0);
		i_host_model.wr(CTRL_OFF, 32'h6);
		tx_buf(2'd0, 16'h83a0, 4'h0, 5'd0, 1'b0, 1'b1);
	endtask

	task automatic rx_frames();
		rx_buf(2'd0, 1'b0, 12'h000, 1'b0, 1'b1);
		rx_buf(2'd1, 1'b1, 12'h5ea, 1'b0, 1'b0);
		rx_buf(2'd2, 1'b1, 12'hfff, 1'b1, 1'b1);
		rx_buf(2'd3, 1'b1, 12'hfff, 1'b0, 1'b1);
	endtask

	initial
	begin
		hresetn = 1'b0;
		{tx_buf_done, underrun_error, late_collision_error, carrier_lost_error} = '0;
		{retry_exhausted_error, waited_for_channel, tx_retries} = '0;
		{rx_buf_done, rx_buf_last, rx_frame_len, rx_frame_err} = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		reset_and_map();
		tx_chain();
		tx_errors();
		rx_frames();
		close_out();
	end
endmodule
